//--- rtl/ira_top.sv
// two-wire slave port that turns bus transfers into internal register accesses
// assumes: sda/scl pins are open drain, resolved outside; link_clk_in runs free
// and samples the pins many times per bit; acc path answers with acc_done_in
`timescale 1ns/10ps
`default_nettype none
module ira_top import ira_pkg::*; #(
	parameter logic [6:0] SLV_ADDR0 = 7'h20,
	parameter logic [6:0] SLV_ADDR1 = 7'h21,
	parameter logic [6:0] SLV_ADDR2 = 7'h22,
	parameter bit HAS_EEPROM = 1'b1
) (
	// device clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// link sampling clock
	input wire logic link_clk_in,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// address strap
	input wire logic [1:0] addr_sel_in,
	// internal access path
	output ira_acc_t acc_out,
	input wire logic [7:0] acc_rdata_in,
	input wire logic acc_done_in,
	output logic memory_bank_select_out
);
	typedef struct packed {
		ira_lst_t st;
		logic scl_q;
		logic sda_q;
		logic [3:0] bitc;
		logic [7:0] shf;
		logic sda_drv;
		logic [1:0] nbyte;
		logic [7:0] cmd;
		logic [15:0] addr;
		logic [15:0] first_addr;
		logic rd;
		logic inc;
		logic inc_ok;
		logic armed;
		logic rd_stat;
		logic mack;
		logic ours_wr;
		logic wrote;
		ira_req_t req;
		logic req_tog;
		logic pend;
		logic ack_q;
		logic [7:0] rbyte;
		logic [1:0] sel;
	} ira_lnk_t;

	ira_lnk_t s_ff;
	ira_lnk_t nxt_s;
	logic [6:0] lsync;
	logic rst_l;
	logic scl_s;
	logic sda_s;
	logic [1:0] sel_s;
	logic ack_s;
	logic bank_s;
	logic req_tog_m;
	logic ack_tog_m;
	logic [7:0] rdata_m;
	logic bank_m;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic fin_armed;
	logic [6:0] my_addr;
	logic do_req;
	ira_req_t rq;

	////////////////////////////////////////////////////////////////////////
	// crossings: pins, reset, answer toggle and bank bit into the link domain
	ira_sync #(.W(7)) u_lsync (
		.clk_in(link_clk_in),
		.d_in({rst_in, scl_in, sda_in, addr_sel_in, ack_tog_m, bank_m}),
		.q_out(lsync)
	);
	assign {rst_l, scl_s, sda_s, sel_s, ack_s, bank_s} = lsync;

	// request toggle into the device domain; the request word is held while pending
	ira_sync #(.W(1)) u_msync (
		.clk_in(mclk_in),
		.d_in(s_ff.req_tog),
		.q_out(req_tog_m)
	);

	ira_bank #(.HAS_EEPROM(HAS_EEPROM)) u_bank (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.req_tog_in(req_tog_m),
		.req_in(s_ff.req),
		.ack_tog_out(ack_tog_m),
		.rdata_out(rdata_m),
		.bank_out(bank_m),
		.acc_out(acc_out),
		.acc_rdata_in(acc_rdata_in),
		.acc_done_in(acc_done_in)
	);

	////////////////////////////////////////////////////////////////////////
	// bus events seen on the synchronised pins
	assign scl_rise = scl_s & ~s_ff.scl_q;
	assign scl_fall = ~scl_s & s_ff.scl_q;
	assign start = scl_s & s_ff.scl_q & s_ff.sda_q & ~sda_s;
	assign stop = scl_s & s_ff.scl_q & ~s_ff.sda_q & sda_s;

	// general call and 10-bit prefixes never equal a strapped address
	assign my_addr = (s_ff.sel == IRA_SEL_A0) ? SLV_ADDR0 :
		(s_ff.sel == IRA_SEL_A1) ? SLV_ADDR1 : SLV_ADDR2;

	// a finished prefix write arms the next read
	assign fin_armed = s_ff.ours_wr &&
		(((s_ff.cmd == IRA_CMD_READ) && (s_ff.nbyte == IRA_NB_DATA)) ||
		((s_ff.cmd == IRA_CMD_RDSR) && (s_ff.nbyte != IRA_NB_CMD)));

	function automatic logic [15:0] wr_next(input logic [15:0] a, input logic ee);
		wr_next = ee ? {a[15:5], a[4:0] + 5'h01} : a + 16'h0001;
	endfunction : wr_next

	always_comb begin
		nxt_s = s_ff;
		do_req = 1'b0;
		rq = '0;
		nxt_s.scl_q = scl_s;
		nxt_s.sda_q = sda_s;
		if (ack_s != s_ff.ack_q) begin
			nxt_s.ack_q = ack_s;
			nxt_s.pend = 1'b0;
			nxt_s.rbyte = rdata_m;
		end
		if (rst_l) begin
			nxt_s = '0;
			nxt_s.st = IRA_L_IDLE;
			nxt_s.sel = sel_s;
			nxt_s.scl_q = scl_s; // start from the pin levels: no false edge after reset
			nxt_s.sda_q = sda_s;
		end else if (start || stop) begin
			// repeated start closes the frame exactly like a stop
			nxt_s.sda_drv = 1'b0;
			nxt_s.bitc = 4'h0;
			nxt_s.ours_wr = 1'b0;
			nxt_s.wrote = 1'b0;
			if (fin_armed) begin
				nxt_s.rd_stat = s_ff.cmd == IRA_CMD_RDSR;
			end
			if (s_ff.ours_wr && (s_ff.cmd == IRA_CMD_WREN) && (s_ff.nbyte == IRA_NB_AHI)) begin
				do_req = 1'b1;
				rq.cmd = IRA_CMD_WREN;
			end else if (s_ff.wrote) begin
				do_req = 1'b1;
				rq.last = 1'b1;
				rq.cmd = IRA_CMD_WRITE;
			end
			if (start) begin
				nxt_s.st = IRA_L_ADDR;
				nxt_s.inc_ok = fin_armed | s_ff.armed;
				nxt_s.armed = 1'b0;
			end else begin
				nxt_s.st = IRA_L_IDLE;
				nxt_s.armed = fin_armed;
			end
		end else begin
			case (s_ff.st)
				IRA_L_IDLE: begin
					nxt_s.sda_drv = 1'b0;
				end
				IRA_L_ADDR: begin
					if (scl_rise) begin
						nxt_s.shf = {s_ff.shf[6:0], sda_s};
						nxt_s.bitc = s_ff.bitc + 4'h1;
					end else if (scl_fall && (s_ff.bitc == IRA_BITS)) begin
						if (s_ff.shf[7:1] == my_addr) begin
							nxt_s.st = IRA_L_ADDR_ACK;
							nxt_s.sda_drv = 1'b1;
							nxt_s.rd = s_ff.shf[0];
							nxt_s.inc = s_ff.inc_ok;
							if (s_ff.shf[0]) begin
								do_req = 1'b1;
								rq.cmd = s_ff.rd_stat ? IRA_CMD_RDSR : IRA_CMD_READ;
								rq.addr = s_ff.inc_ok ? s_ff.addr : s_ff.first_addr;
								if (s_ff.inc_ok) begin
									nxt_s.addr = s_ff.addr + 16'h0001;
								end
							end else begin
								nxt_s.ours_wr = 1'b1;
								nxt_s.nbyte = IRA_NB_CMD;
							end
						end else begin
							nxt_s.st = IRA_L_IDLE;
						end
					end
				end
				IRA_L_ADDR_ACK: begin
					if (scl_fall) begin
						nxt_s.bitc = 4'h0;
						if (s_ff.rd) begin
							nxt_s.st = IRA_L_RD;
							nxt_s.shf = nxt_s.rbyte;
							nxt_s.sda_drv = ~nxt_s.rbyte[7];
						end else begin
							nxt_s.st = IRA_L_WR;
							nxt_s.sda_drv = 1'b0;
						end
					end
				end
				IRA_L_WR: begin
					if (scl_rise) begin
						nxt_s.shf = {s_ff.shf[6:0], sda_s};
						nxt_s.bitc = s_ff.bitc + 4'h1;
					end else if (scl_fall && (s_ff.bitc == IRA_BITS)) begin
						nxt_s.st = IRA_L_WR_ACK;
						nxt_s.sda_drv = 1'b1;
						case (s_ff.nbyte)
							IRA_NB_CMD: begin
								nxt_s.cmd = s_ff.shf;
								nxt_s.nbyte = IRA_NB_AHI;
							end
							IRA_NB_AHI: begin
								nxt_s.addr[15:8] = s_ff.shf;
								nxt_s.nbyte = IRA_NB_ALO;
							end
							IRA_NB_ALO: begin
								nxt_s.addr[7:0] = s_ff.shf;
								nxt_s.first_addr = {s_ff.addr[15:8], s_ff.shf};
								nxt_s.nbyte = IRA_NB_DATA;
							end
							default: begin
								if (s_ff.cmd == IRA_CMD_WRITE) begin
									do_req = 1'b1;
									rq.cmd = IRA_CMD_WRITE;
									rq.addr = s_ff.addr;
									rq.data = s_ff.shf;
									nxt_s.wrote = 1'b1;
									nxt_s.addr = wr_next(s_ff.addr, bank_s);
								end
							end
						endcase
					end
				end
				IRA_L_WR_ACK: begin
					if (scl_fall) begin
						nxt_s.st = IRA_L_WR;
						nxt_s.sda_drv = 1'b0;
						nxt_s.bitc = 4'h0;
					end
				end
				IRA_L_RD: begin
					if (scl_rise) begin
						nxt_s.bitc = s_ff.bitc + 4'h1;
					end else if (scl_fall) begin
						if (s_ff.bitc == IRA_BITS) begin
							nxt_s.st = IRA_L_RD_ACK;
							nxt_s.sda_drv = 1'b0;
						end else begin
							nxt_s.shf = {s_ff.shf[6:0], 1'b0};
							nxt_s.sda_drv = ~s_ff.shf[6];
						end
					end
				end
				IRA_L_RD_ACK: begin
					if (scl_rise) begin
						nxt_s.mack = ~sda_s;
						if (!sda_s) begin
							do_req = 1'b1;
							rq.cmd = s_ff.rd_stat ? IRA_CMD_RDSR : IRA_CMD_READ;
							rq.addr = s_ff.inc ? s_ff.addr : s_ff.first_addr;
							if (s_ff.inc) begin
								nxt_s.addr = s_ff.addr + 16'h0001;
							end
						end
					end else if (scl_fall) begin
						nxt_s.bitc = 4'h0;
						if (s_ff.mack) begin
							nxt_s.st = IRA_L_RD;
							nxt_s.shf = nxt_s.rbyte;
							nxt_s.sda_drv = ~nxt_s.rbyte[7];
						end else begin
							nxt_s.st = IRA_L_IDLE;
						end
					end
				end
				default: begin
					nxt_s.st = IRA_L_IDLE;
					nxt_s.sda_drv = 1'b0;
				end
			endcase
		end
		// one request in flight; a byte period dwarfs the crossing delay
		if (do_req && !nxt_s.pend && !rst_l) begin
			nxt_s.req = rq;
			nxt_s.req_tog = ~s_ff.req_tog;
			nxt_s.pend = 1'b1;
		end
	end

	always_ff @(posedge link_clk_in) begin
		s_ff <= nxt_s;
	end

	// only sda is ever pulled; scl has no driver here, so no clock stretching
	assign sda_out = 1'b0;
	assign sda_oe_out = s_ff.sda_drv;
	assign memory_bank_select_out = bank_m;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge link_clk_in); endclocking
	default disable iff (rst_l);

	chk_idle_quiet: assert property ((s_ff.st == IRA_L_IDLE) |-> !sda_oe_out)
		else $error("sda driven while idle");
	chk_start_frame: assert property (start |=> (s_ff.st == IRA_L_ADDR) && (s_ff.bitc == 4'h0) && !sda_oe_out)
		else $error("start did not reopen the address phase");
	chk_stop_frame: assert property (stop |=> (s_ff.st == IRA_L_IDLE) && !sda_oe_out)
		else $error("stop did not release the bus");
	chk_ack_drive: assert property (((s_ff.st == IRA_L_ADDR_ACK) || (s_ff.st == IRA_L_WR_ACK)) |-> sda_oe_out)
		else $error("acknowledge not driven");
	chk_addr_match: assert property ((s_ff.st == IRA_L_ADDR) && scl_fall && (s_ff.bitc == IRA_BITS) && !start && !stop
		&& (s_ff.shf[7:1] != my_addr) |=> (s_ff.st == IRA_L_IDLE))
		else $error("foreign address not ignored");
	chk_master_ack: assert property ((s_ff.st == IRA_L_RD_ACK) |-> !sda_oe_out)
		else $error("sda driven in master acknowledge slot");
	chk_fetch_ack: assert property ((s_ff.st == IRA_L_RD_ACK) && scl_rise && !sda_s && !start && !stop && !s_ff.pend
		|=> s_ff.pend && (s_ff.req_tog != $past(s_ff.req_tog)) && !s_ff.req.last)
		else $error("no fetch at master acknowledge");
	chk_addr_adv: assert property ((s_ff.st == IRA_L_RD_ACK) && scl_rise && !sda_s && !start && !stop && s_ff.inc
		|=> s_ff.addr == $past(s_ff.addr) + 16'h0001)
		else $error("read address did not advance");
	chk_page_wrap: assert property ((s_ff.st == IRA_L_WR) && scl_fall && (s_ff.bitc == IRA_BITS) && !start && !stop
		&& (s_ff.nbyte == IRA_NB_DATA) && (s_ff.cmd == IRA_CMD_WRITE) && bank_s && (s_ff.addr[4:0] == 5'h1F)
		|=> (s_ff.addr[4:0] == 5'h00) && (s_ff.addr[15:5] == $past(s_ff.addr[15:5])))
		else $error("memory write address left its page");
	chk_msb_out: assert property ((s_ff.st == IRA_L_ADDR_ACK) && s_ff.rd && scl_fall && !start && !stop
		|=> sda_oe_out == !s_ff.shf[7])
		else $error("read byte not started at its top bit");

	cov_read_nack: cover property ((s_ff.st == IRA_L_RD_ACK) && scl_fall && !s_ff.mack);
	cov_write_data: cover property ((s_ff.st == IRA_L_WR_ACK) && s_ff.wrote);
	cov_rep_start: cover property (start && (s_ff.st != IRA_L_IDLE));
endmodule : ira_top
`default_nettype wire

//--- rtl/ira_pkg.sv
// constants and types shared by the two-wire register access bridge
// assumes: one device clock (mclk) and one free-running link sampling clock
package ira_pkg;

	localparam int IRA_RATE_KBPS = 400;
	localparam logic [7:0] IRA_CMD_WREN = 8'h06;
	localparam logic [7:0] IRA_CMD_WRITE = 8'h02;
	localparam logic [7:0] IRA_CMD_READ = 8'h03;
	localparam logic [7:0] IRA_CMD_RDSR = 8'h05;
	localparam logic [15:0] IRA_BANK_ADDR = 16'h0000;
	localparam logic [3:0] IRA_BITS = 4'h8;
	localparam logic [1:0] IRA_NB_CMD = 2'h0;
	localparam logic [1:0] IRA_NB_AHI = 2'h1;
	localparam logic [1:0] IRA_NB_ALO = 2'h2;
	localparam logic [1:0] IRA_NB_DATA = 2'h3;
	localparam logic [1:0] IRA_SEL_A0 = 2'h0;
	localparam logic [1:0] IRA_SEL_A1 = 2'h1;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic last;
		logic [7:0] cmd;
		logic [15:0] addr;
		logic [7:0] data;
	} ira_req_t;

	typedef struct packed {
		logic req;
		logic last;
		logic eeprom;
		logic [7:0] cmd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ira_acc_t;

	typedef enum logic [6:0] {
		IRA_L_IDLE = 7'h01,
		IRA_L_ADDR = 7'h02,
		IRA_L_ADDR_ACK = 7'h04,
		IRA_L_WR = 7'h08,
		IRA_L_WR_ACK = 7'h10,
		IRA_L_RD = 7'h20,
		IRA_L_RD_ACK = 7'h40
	} ira_lst_t;

	typedef enum logic [1:0] {
		IRA_B_IDLE = 2'h1,
		IRA_B_WAIT = 2'h2
	} ira_bst_t;

	typedef struct packed {
		ira_bst_t st;
		logic tog_q;
		logic ack_tog;
		logic [7:0] rdata;
		logic bank;
		ira_acc_t acc;
	} ira_bnk_t;

endpackage : ira_pkg

//--- rtl/ira_sync.sv
// two flip-flop level synchroniser, one per bit of the bus
// assumes: each bit is a level or a toggle that is stable for several clocks
`timescale 1ns/10ps
`default_nettype none
module ira_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic clk_in,
	// data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} ira_sync_st_t;

	ira_sync_st_t s_ff;
	ira_sync_st_t nxt_s;

	always_comb begin
		nxt_s.s1 = d_in;
		nxt_s.s2 = s_ff.s1;
	end

	always_ff @(posedge clk_in) begin
		s_ff <= nxt_s;
	end

	assign q_out = s_ff.s2;
endmodule : ira_sync
`default_nettype wire

//--- rtl/ira_bank.sv
// device-clock side: bank select register and forwarding to the access path
// assumes: req_in is stable while its toggle crosses; acc_done_in answers every acc_out.req that is not last
`timescale 1ns/10ps
`default_nettype none
module ira_bank import ira_pkg::*; #(
	parameter bit HAS_EEPROM = 1'b1
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// crossing from the link side
	input wire logic req_tog_in,
	input wire ira_req_t req_in,
	output logic ack_tog_out,
	output logic [7:0] rdata_out,
	output logic bank_out,
	// internal access path
	output ira_acc_t acc_out,
	input wire logic [7:0] acc_rdata_in,
	input wire logic acc_done_in
);
	ira_bnk_t s_ff;
	ira_bnk_t nxt_s;
	logic fresh;
	logic is_bank;
	logic is_ee_cmd;

	assign fresh = req_tog_in != s_ff.tog_q;
	assign is_bank = (req_in.addr == IRA_BANK_ADDR) && ((req_in.cmd == IRA_CMD_WRITE) || (req_in.cmd == IRA_CMD_READ));
	assign is_ee_cmd = (req_in.cmd == IRA_CMD_WREN) || (req_in.cmd == IRA_CMD_RDSR);

	always_comb begin
		nxt_s = s_ff;
		nxt_s.acc.req = 1'b0;
		if (rst_in) begin
			nxt_s = '0;
			nxt_s.st = IRA_B_IDLE;
		end else begin
			case (s_ff.st)
				IRA_B_IDLE: begin
					if (fresh) begin
						nxt_s.tog_q = req_tog_in;
						nxt_s.acc.last = req_in.last;
						nxt_s.acc.cmd = req_in.cmd;
						nxt_s.acc.addr = req_in.addr;
						nxt_s.acc.wdata = req_in.data;
						nxt_s.acc.eeprom = s_ff.bank;
						if (req_in.last) begin
							nxt_s.acc.req = 1'b1;
							nxt_s.ack_tog = ~s_ff.ack_tog;
						end else if (is_bank) begin
							// the bank bit itself is visible in both banks
							if (req_in.cmd == IRA_CMD_WRITE) begin
								nxt_s.bank = HAS_EEPROM & req_in.data[0];
							end
							nxt_s.rdata = {7'h00, s_ff.bank};
							nxt_s.ack_tog = ~s_ff.ack_tog;
						end else if (is_ee_cmd && !HAS_EEPROM) begin
							nxt_s.rdata = 8'h00;
							nxt_s.ack_tog = ~s_ff.ack_tog;
						end else begin
							nxt_s.acc.req = 1'b1;
							nxt_s.acc.eeprom = is_ee_cmd | s_ff.bank;
							nxt_s.st = IRA_B_WAIT;
						end
					end
				end
				IRA_B_WAIT: begin
					if (acc_done_in) begin
						nxt_s.rdata = acc_rdata_in;
						nxt_s.ack_tog = ~s_ff.ack_tog;
						nxt_s.st = IRA_B_IDLE;
					end
				end
				default: begin
					nxt_s.st = IRA_B_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		s_ff <= nxt_s;
	end

	assign ack_tog_out = s_ff.ack_tog;
	assign rdata_out = s_ff.rdata;
	assign bank_out = s_ff.bank;
	assign acc_out = s_ff.acc;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	chk_bank_variant: assert property (!HAS_EEPROM |-> !s_ff.bank)
		else $error("bank select set on a variant without memory");
	chk_bank_write: assert property ((s_ff.st == IRA_B_IDLE) && fresh && !req_in.last && is_bank
		&& (req_in.cmd == IRA_CMD_WRITE) |=> s_ff.bank == (HAS_EEPROM & $past(req_in.data[0])))
		else $error("bank select not taken from the written byte");
	chk_fwd_access: assert property ((s_ff.st == IRA_B_IDLE) && fresh && !req_in.last && !is_bank && !is_ee_cmd
		|=> acc_out.req && (acc_out.addr == $past(req_in.addr)) && (acc_out.eeprom == $past(s_ff.bank)))
		else $error("register access not forwarded on the selected path");
	cov_forward: cover property (acc_out.req && !acc_out.last);
endmodule : ira_bank
`default_nettype wire

//--- verification/ira_mst_model.sv
// behavioural two-wire bus master standing on the far side of the bridge
// assumes: sda_in is the resolved wire with pull-up; scl is driven only here
`timescale 1ns/10ps
`default_nettype none
module ira_mst_model #(
	parameter int Q = 25
) (
	// clock
	input wire logic clk_in,
	// bus
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_pull_out
);
	// clock stands high between frames
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	task automatic hp();
		repeat (Q) @(posedge clk_in);
	endtask : hp
	// data is held a while after scl falls: the slave oversamples through a synchroniser
	task automatic wr_bit(input logic b);
		sda_pull_out <= !b;
		hp();
		scl_out <= 1'b1;
		hp();
		scl_out <= 1'b0;
		repeat (Q / 2) @(posedge clk_in);
	endtask : wr_bit
	task automatic rd_bit(output logic b);
		sda_pull_out <= 1'b0;
		hp();
		scl_out <= 1'b1;
		hp();
		b = sda_in;
		scl_out <= 1'b0;
		repeat (Q / 2) @(posedge clk_in);
	endtask : rd_bit
	// works from idle and as a repeated start
	task automatic start_bit();
		sda_pull_out <= 1'b0;
		hp();
		scl_out <= 1'b1;
		hp();
		sda_pull_out <= 1'b1;
		hp();
		scl_out <= 1'b0;
		repeat (Q / 2) @(posedge clk_in);
	endtask : start_bit
	task automatic stop_bit();
		sda_pull_out <= 1'b1;
		hp();
		scl_out <= 1'b1;
		hp();
		sda_pull_out <= 1'b0;
		hp();
	endtask : stop_bit
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) wr_bit(d[i]);
		rd_bit(g);
		ack = !g;
	endtask : wbyte
	task automatic rbyte(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) rd_bit(d[i]);
		wr_bit(!ack);
	endtask : rbyte
endmodule : ira_mst_model
`default_nettype wire

//--- verification/ira_top_tb_top.sv
// self-checking bench: bus master model on the pins, access path model on acc_out
// assumes: bus runs faster than the real rate so the run stays short
`timescale 1ns/10ps
`default_nettype none
module ira_top_tb_top import ira_pkg::*;;
	localparam logic [6:0] A0 = 7'h20;
	localparam logic [6:0] A1 = 7'h21;
	localparam logic [6:0] A2 = 7'h22;
	logic mclk_in, link_clk_in, rst_in, scl, sda_pull, sda_out, sda_oe_out, bank, acc_done_in;
	logic [1:0] addr_sel_in;
	logic [7:0] acc_rdata_in, status_r;
	logic [23:0] got;
	ira_acc_t acc_out;
	ira_acc_t log_q[$];
	int mismatches, n_checks;
	wire logic sda_w;
	assign sda_w = (sda_oe_out ? sda_out : 1'b1) & !sda_pull;
	ira_top #(.SLV_ADDR0(A0), .SLV_ADDR1(A1), .SLV_ADDR2(A2), .HAS_EEPROM(1'b1)) u_dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in), .acc_out(acc_out),
		.acc_rdata_in(acc_rdata_in), .acc_done_in(acc_done_in), .memory_bank_select_out(bank));
	ira_mst_model #(.Q(25)) u_mst (.clk_in(mclk_in), .sda_in(sda_w), .scl_out(scl), .sda_pull_out(sda_pull));
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	// link clock phase deliberately offset from mclk
	initial begin
		link_clk_in = 1'b0;
		#1.3;
		forever #3 link_clk_in = ~link_clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rv(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : rv
	// access path: answers each non-final request on the next cycle
	always @(posedge mclk_in) begin
		acc_done_in <= 1'b0;
		if (rst_in) begin
			log_q.delete();
		end else if (acc_out.req === 1'b1) begin
			log_q.push_back(acc_out);
			if (!acc_out.last) begin
				acc_done_in <= 1'b1;
				acc_rdata_in <= (acc_out.cmd == IRA_CMD_RDSR) ? status_r : rv(acc_out.addr);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	task automatic chk_bit(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t bit got %b exp %b", $time, g, e);
		end
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t byte got %h exp %h", $time, g, e);
		end
	endtask : chk_byte
	// m: 0 fetch, 1 store with data, 2 frame end, 3 command only
	task automatic chk_acc(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, input logic ee,
		input logic [1:0] m);
		ira_acc_t e;
		logic ok;
		n_checks++;
		e = '0;
		if (log_q.size() > 0) e = log_q.pop_front();
		ok = (e.req === 1'b1) && (e.cmd === c);
		if (m == 2'h2) ok = ok && (e.last === 1'b1);
		else ok = ok && (e.eeprom === ee) && (m == 2'h3 || (e.addr === a && e.last === 1'b0
			&& (m == 2'h0 || e.wdata === d)));
		if (!ok) begin
			mismatches++;
			$display("[ERR] %0t access got %h/%h/%h exp %h/%h/%h", $time, e.cmd, e.addr, e.wdata, c, a, d);
		end
	endtask : chk_acc
	task automatic do_reset(input logic [1:0] sel);
		@(posedge mclk_in);
		addr_sel_in <= sel;
		rst_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
	endtask : do_reset
	task automatic wr(input logic [6:0] a, input int n, input logic [47:0] b, input logic ak, input logic sr);
		logic g;
		u_mst.start_bit();
		u_mst.wbyte({a, 1'b0}, g);
		chk_bit(g, ak);
		for (int i = 0; i < n; i++) begin
			u_mst.wbyte(b[47 - 8 * i -: 8], g);
			chk_bit(g, 1'b1);
		end
		if (!sr) u_mst.stop_bit();
		repeat (20) @(posedge mclk_in);
	endtask : wr
	task automatic rd(input logic [6:0] a, input int n);
		logic g;
		logic [7:0] d;
		got = '0;
		u_mst.start_bit();
		u_mst.wbyte({a, 1'b1}, g);
		chk_bit(g, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_mst.rbyte(d, i < n - 1);
			got = {got[15:0], d};
		end
		u_mst.stop_bit();
		repeat (20) @(posedge mclk_in);
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	task automatic t_write();
		wr(A0, 5, {IRA_CMD_WRITE, 16'h0010, 8'hAA, 8'hBB, 8'h00}, 1'b1, 1'b0);
		chk_acc(IRA_CMD_WRITE, 16'h0010, 8'hAA, 1'b0, 2'h1);
		chk_acc(IRA_CMD_WRITE, 16'h0011, 8'hBB, 1'b0, 2'h1);
		chk_acc(IRA_CMD_WRITE, 16'h0000, 8'h00, 1'b0, 2'h2);
		chk_bit(log_q.size() == 0, 1'b1);
	endtask : t_write
	// first pass uses a repeated start, second a stop then start: both must increment
	task automatic t_read();
		for (int k = 0; k < 2; k++) begin
			wr(A0, 3, {IRA_CMD_READ, 16'h0020 + 16'(k * 32), 24'h0}, 1'b1, k == 0);
			rd(A0, 3);
			for (int i = 0; i < 3; i++) begin
				chk_byte(got[23 - 8 * i -: 8], rv(16'h0020 + 16'(k * 32 + i)));
				chk_acc(IRA_CMD_READ, 16'h0020 + 16'(k * 32 + i), 8'h00, 1'b0, 2'h0);
			end
		end
	endtask : t_read
	task automatic t_repeat();
		logic [6:0] fa[3];
		fa = '{7'h00, A1, 7'h78};
		for (int i = 0; i < 3; i++) wr(fa[i], 0, 48'h0, 1'b0, 1'b0);
		wr(A0, 3, {IRA_CMD_READ, 16'h0030, 24'h0}, 1'b1, 1'b0);
		wr(A0, 1, {8'h07, 40'h0}, 1'b1, 1'b0);
		rd(A0, 2);
		chk_byte(got[15:8], rv(16'h0030));
		chk_byte(got[7:0], rv(16'h0030));
		chk_acc(IRA_CMD_READ, 16'h0030, 8'h00, 1'b0, 2'h0);
		chk_acc(IRA_CMD_READ, 16'h0030, 8'h00, 1'b0, 2'h0);
		chk_bit(log_q.size() == 0, 1'b1);
	endtask : t_repeat
	task automatic t_eeprom();
		wr(A0, 4, {IRA_CMD_WRITE, 16'h0000, 8'h01, 16'h0}, 1'b1, 1'b0);
		chk_bit(bank, 1'b1);
		chk_acc(IRA_CMD_WRITE, 16'h0000, 8'h00, 1'b1, 2'h2);
		chk_bit(log_q.size() == 0, 1'b1);
		wr(A0, 1, {IRA_CMD_WREN, 40'h0}, 1'b1, 1'b0);
		chk_acc(IRA_CMD_WREN, 16'h0000, 8'h00, 1'b1, 2'h3);
		wr(A0, 6, {IRA_CMD_WRITE, 16'h011E, 8'hD0, 8'hD1, 8'hD2}, 1'b1, 1'b0);
		chk_acc(IRA_CMD_WRITE, 16'h011E, 8'hD0, 1'b1, 2'h1);
		chk_acc(IRA_CMD_WRITE, 16'h011F, 8'hD1, 1'b1, 2'h1);
		chk_acc(IRA_CMD_WRITE, 16'h0100, 8'hD2, 1'b1, 2'h1);
		chk_acc(IRA_CMD_WRITE, 16'h0000, 8'h00, 1'b1, 2'h2);
		for (int k = 0; k < 2; k++) begin
			status_r = (k == 0) ? 8'h01 : 8'h00;
			wr(A0, 1, {IRA_CMD_RDSR, 40'h0}, 1'b1, 1'b1);
			rd(A0, 1);
			chk_byte(got[7:0], status_r);
			chk_acc(IRA_CMD_RDSR, 16'h0000, 8'h00, 1'b1, 2'h3);
		end
		wr(A0, 4, {IRA_CMD_WRITE, 16'h0000, 8'h00, 16'h0}, 1'b1, 1'b0);
		chk_bit(bank, 1'b0);
	endtask : t_eeprom
	task automatic t_strap();
		do_reset(2'b10);
		wr(A0, 0, 48'h0, 1'b0, 1'b0);
		wr(A2, 4, {IRA_CMD_WRITE, 16'h0040, 8'h5C, 16'h0}, 1'b1, 1'b0);
		chk_acc(IRA_CMD_WRITE, 16'h0040, 8'h5C, 1'b0, 2'h1);
	endtask : t_strap
	// limit sized well above the whole sequence, about 41k cycles
	initial begin
		repeat (90000) @(posedge mclk_in);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
	initial begin
		rst_in = 1'b1;
		addr_sel_in = 2'b00;
		acc_rdata_in = 8'h00;
		acc_done_in = 1'b0;
		status_r = 8'h00;
		mismatches = 0;
		n_checks = 0;
		do_reset(2'b00);
		t_write();
		t_read();
		t_repeat();
		t_eeprom();
		t_strap();
		final_report();
	end
endmodule : ira_top_tb_top
`default_nettype wire
